// ===== hdl/bse_core.sv
// Behaviour
// - Two full banks, one visible at once.
// - Signed 8-bit code, positive shifts left.
// - Code from exponent, its negation, or immediate.
// - Zero code lands mid or low word.
// - Zeros below input, extension bit above.
// - Extension is input MSB, carry, or zero.
// - Merge ORs array into current result.
// - Without merge, array replaces result.
// - Upper code c equals lower c+16.
// - Upper detect gives negative redundant sign count.
// - Extended detect gives plus one on overflow.
// - Upper modes write sign flag, overflow inverts it in extended mode only.
// - Lower detect uses stored sign flag.
// - Lower detect updates exponent only at minus fifteen.
// - Lower detect result offset by minus sixteen.
// - Block exponent overwritten only when larger.
// - Register file: sixteen words per bank.
// - One program and one data transfer per cycle.
// - Result is forty bits in three words.
// - Exponent is 8-bit, sign-extended on read.
// - Block exponent is 5-bit, sign-extended on read.
// - Status write switches bank a cycle later.
`include "bse_params.svh"
`default_nettype none

module bse_core (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic [7:0]      paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire bse_pkg::bse_op_t op,
  input  wire logic            alu_carry_flag,
  input  wire logic            alu_overflow_flag,
  input  wire logic            alt_bank_enable,
  input  wire logic            alt_bank_disable,
  input  wire bse_pkg::bse_rf_req_t dm_req,
  input  wire bse_pkg::bse_rf_req_t pm_req,
  output logic      [15:0]     dm_rdata,
  output logic      [15:0]     pm_rdata,
  output logic                 shift_sign_flag,
  output logic                 alt_bank_active
);

  logic [7:0]  shift_exponent_reg [2];
  logic [4:0]  block_exponent_reg [2];
  logic [15:0] shift_input_reg    [2];
  logic [39:0] shift_result_reg   [2];
  logic [15:0] rf_q               [2][16];
  logic        mode_status_reg;
  logic        bank;
  logic        apb_wr;
  logic        apb_setup;
  logic        mapped;
  logic        sr_apb_wr;
  logic [15:0] in_val;
  logic [7:0]  se_cur;
  logic [39:0] sr_cur;
  logic [7:0]  code;
  logic [8:0]  lref;
  logic [8:0]  nsh;
  logic        ext;
  logic [39:0] base;
  logic [79:0] wide_sh;
  logic [39:0] arr;
  logic [4:0]  lead_n;
  logic [7:0]  exp_det;
  logic        is_shift;
  logic        is_exp;
  logic        is_adj;
  logic        se_upd;
  logic [31:0] next_prdata;

  function automatic logic [4:0] lead_cnt(input logic [15:0] v, input logic s);
    logic [4:0] n;
    logic       stop;
    n    = 5'h00;
    stop = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (!stop && v[i] == s) begin
        n = n + 5'h01;
      end else begin
        stop = 1'b1;
      end
    end
    return n;
  endfunction : lead_cnt

  // The slave never waits, so every access phase completes in one cycle.
  assign pready    = 1'b1;
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;

  always_comb begin
    unique case (paddr)
      `BSE_OFS_SE, `BSE_OFS_SB, `BSE_OFS_SI, `BSE_OFS_SR0, `BSE_OFS_SR1,
      `BSE_OFS_SR2, `BSE_OFS_MODE_STATUS_REG, `BSE_OFS_ARITH_STATUS_REG: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr   = psel && penable && !mapped;
  assign sr_apb_wr = apb_wr && (paddr == `BSE_OFS_SR0 || paddr == `BSE_OFS_SR1 ||
                                paddr == `BSE_OFS_SR2);

  // Operand fetch sees only the values stored at the previous edge.
  assign se_cur   = shift_exponent_reg[bank];
  assign sr_cur   = shift_result_reg[bank];
  assign in_val   = op.use_si ? shift_input_reg[bank] : rf_q[bank][op.src];
  assign is_shift = op.valid && op.kind == bse_pkg::BSE_OP_SHIFT;
  assign is_exp   = op.valid && op.kind == bse_pkg::BSE_OP_EXP;
  assign is_adj   = op.valid && op.kind == bse_pkg::BSE_OP_EXPADJ;

  always_comb begin
    unique case (op.code_src)
      bse_pkg::BSE_CODE_SE:     code = se_cur;
      bse_pkg::BSE_CODE_NEG_SE: code = ~se_cur + 8'h01;
      default:                  code = op.imm;
    endcase
  end

  always_comb begin
    unique case (op.ext_src)
      bse_pkg::BSE_EXT_MSB:   ext = in_val[15];
      bse_pkg::BSE_EXT_CARRY: ext = alu_carry_flag;
      default:                ext = 1'b0;
    endcase
  end

  // The array is built around the lower reference; an upper code is the same
  // placement sixteen places higher, which keeps a single shift network.
  assign lref    = {code[7], code} + (op.upper_reference ? `BSE_HI_REF_OFS : 9'h000);
  assign nsh     = ~lref + 9'h001;
  assign base    = {{24{ext}}, in_val};
  assign wide_sh = {{40{ext}}, base} >> nsh;

  always_comb begin
    if (!lref[8]) begin
      arr = base << lref;
    end else if (nsh >= `BSE_ARR_WIDTH) begin
      // A plain right shift would pull zeros in once it runs past the window.
      arr = {40{ext}};
    end else begin
      arr = wide_sh[39:0];
    end
  end

  always_comb begin
    lead_n  = lead_cnt(in_val, in_val[15]);
    exp_det = `BSE_HI_EXP_BASE - {3'h0, lead_n};
    unique case (op.det_mode)
      bse_pkg::BSE_DET_HIX: begin
        if (alu_overflow_flag) begin
          exp_det = `BSE_OVF_EXP;
        end
      end
      bse_pkg::BSE_DET_LO: begin
        lead_n  = lead_cnt(in_val, shift_sign_flag);
        exp_det = `BSE_LO_EXP_BASE - {3'h0, lead_n};
      end
      default: begin
      end
    endcase
  end

  assign se_upd = is_exp && (op.det_mode != bse_pkg::BSE_DET_LO ||
                             se_cur == `BSE_SE_ALL_SIGN);

  // Bank select: the status write lands first, the bank follows one edge later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_status_reg <= 1'b0;
      bank            <= 1'b0;
    end else if (alt_bank_enable || alt_bank_disable) begin
      mode_status_reg <= alt_bank_enable;
      bank            <= alt_bank_enable;
    end else begin
      if (apb_wr && paddr == `BSE_OFS_MODE_STATUS_REG) begin
        mode_status_reg <= pwdata[`BSE_BANK_BIT];
      end
      bank <= mode_status_reg;
    end
  end

  assign alt_bank_active = bank;

  // Bus moves outrank compute results when both aim at one register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < 2; b++) begin
        shift_exponent_reg[b] <= `BSE_SE_RST;
      end
    end else if (apb_wr && paddr == `BSE_OFS_SE) begin
      shift_exponent_reg[bank] <= pwdata[7:0];
    end else if (se_upd) begin
      shift_exponent_reg[bank] <= exp_det;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < 2; b++) begin
        block_exponent_reg[b] <= `BSE_SB_RST;
      end
    end else if (apb_wr && paddr == `BSE_OFS_SB) begin
      block_exponent_reg[bank] <= pwdata[4:0];
    end else if (is_adj && $signed(exp_det) >
                 $signed({{3{block_exponent_reg[bank][4]}}, block_exponent_reg[bank]})) begin
      block_exponent_reg[bank] <= exp_det[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < 2; b++) begin
        shift_input_reg[b] <= `BSE_WORD_RST;
      end
    end else if (apb_wr && paddr == `BSE_OFS_SI) begin
      shift_input_reg[bank] <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < 2; b++) begin
        shift_result_reg[b] <= `BSE_SR_RST;
      end
    end else if (sr_apb_wr) begin
      unique case (paddr)
        `BSE_OFS_SR0: shift_result_reg[bank][15:0]  <= pwdata[15:0];
        `BSE_OFS_SR1: shift_result_reg[bank][31:16] <= pwdata[15:0];
        default:      shift_result_reg[bank][39:32] <= pwdata[7:0];
      endcase
    end else if (is_shift) begin
      if (op.merge_option) begin
        shift_result_reg[bank] <= sr_cur | arr;
      end else begin
        shift_result_reg[bank] <= arr;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_sign_flag <= 1'b0;
    end else if (apb_wr && paddr == `BSE_OFS_ARITH_STATUS_REG) begin
      shift_sign_flag <= pwdata[`BSE_SS_BIT];
    end else if (is_exp && op.det_mode != bse_pkg::BSE_DET_LO) begin
      shift_sign_flag <= in_val[15] ^ (op.det_mode == bse_pkg::BSE_DET_HIX &&
                                       alu_overflow_flag);
    end
  end

  // Data memory wins when both buses write the same word in one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < 2; b++) begin
        for (int r = 0; r < 16; r++) begin
          rf_q[b][r] <= `BSE_WORD_RST;
        end
      end
    end else begin
      if (pm_req.en && pm_req.we) begin
        rf_q[bank][pm_req.addr] <= pm_req.wdata;
      end
      if (dm_req.en && dm_req.we) begin
        rf_q[bank][dm_req.addr] <= dm_req.wdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dm_rdata <= `BSE_WORD_RST;
      pm_rdata <= `BSE_WORD_RST;
    end else begin
      if (dm_req.en && !dm_req.we) begin
        dm_rdata <= rf_q[bank][dm_req.addr];
      end
      if (pm_req.en && !pm_req.we) begin
        pm_rdata <= rf_q[bank][pm_req.addr];
      end
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      `BSE_OFS_SE:    next_prdata[15:0] = {{8{se_cur[7]}}, se_cur};
      `BSE_OFS_SB:    next_prdata[15:0] = {{11{block_exponent_reg[bank][4]}},
                                           block_exponent_reg[bank]};
      `BSE_OFS_SI:    next_prdata[15:0] = shift_input_reg[bank];
      `BSE_OFS_SR0:   next_prdata[15:0] = sr_cur[15:0];
      `BSE_OFS_SR1:   next_prdata[15:0] = sr_cur[31:16];
      `BSE_OFS_SR2:   next_prdata[7:0]  = sr_cur[39:32];
      `BSE_OFS_MODE_STATUS_REG: next_prdata[`BSE_BANK_BIT] = mode_status_reg;
      `BSE_OFS_ARITH_STATUS_REG: next_prdata[`BSE_SS_BIT] = shift_sign_flag;
      default:        next_prdata = 32'h0000_0000;
    endcase
  end

  // Read data is captured at the end of setup so it stands through the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bank_follow: assert property (
    (mode_status_reg != bank) && !alt_bank_enable && !alt_bank_disable
    |=> bank == $past(mode_status_reg))
    else $error("bank did not follow the status bit one cycle later");

  a_merge_or: assert property (
    is_shift && op.merge_option && !sr_apb_wr
    |=> shift_result_reg[$past(bank)] == ($past(sr_cur) | $past(arr)))
    else $error("merged result is not the OR of array and old result");

  a_pass_thru: assert property (
    is_shift && !op.merge_option && !sr_apb_wr
    |=> shift_result_reg[$past(bank)] == $past(arr))
    else $error("unmerged result differs from array output");

  a_hi_zero: assert property (
    is_shift && op.upper_reference && !code[7] && code >= `BSE_HI_ZERO_MIN
    |-> arr == 40'h00_0000_0000)
    else $error("upper code at or above 24 did not give zero");

  a_hi_ext: assert property (
    is_shift && op.upper_reference && code[7] && code <= `BSE_HI_EXT_MAX
    |-> arr == {40{ext}})
    else $error("upper code at or below -32 did not give all extension bits");

  a_mid_place: assert property (
    is_shift && op.upper_reference && code == 8'h00
    |-> arr[31:16] == in_val && arr[15:0] == 16'h0000)
    else $error("upper zero code did not place input in the middle word");

  a_hix_ovf: assert property (
    is_exp && op.det_mode == bse_pkg::BSE_DET_HIX && alu_overflow_flag
    && !(apb_wr && paddr == `BSE_OFS_SE)
    |=> shift_exponent_reg[$past(bank)] == `BSE_OVF_EXP)
    else $error("overflowed extended detect did not give plus one");

  a_lo_hold: assert property (
    is_exp && op.det_mode == bse_pkg::BSE_DET_LO && se_cur != `BSE_SE_ALL_SIGN
    && !(apb_wr && paddr == `BSE_OFS_SE)
    |=> shift_exponent_reg[$past(bank)] == $past(se_cur))
    else $error("lower detect changed the exponent without minus fifteen");

  a_sb_grow: assert property (
    is_adj && !(apb_wr && paddr == `BSE_OFS_SB)
    |=> $signed(block_exponent_reg[$past(bank)]) >= $signed($past(block_exponent_reg[bank])))
    else $error("block exponent decreased on a compare");

  a_ss_hi: assert property (
    is_exp && op.det_mode == bse_pkg::BSE_DET_HI && !(apb_wr && paddr == `BSE_OFS_ARITH_STATUS_REG)
    |=> shift_sign_flag == $past(in_val[15]))
    else $error("upper detect did not load the input sign");

endmodule : bse_core

`default_nettype wire

// ===== hdl/bse_params.svh
`ifndef BSE_PARAMS_SVH
`define BSE_PARAMS_SVH

// Register byte offsets on the APB.
`define BSE_OFS_SE        8'h00
`define BSE_OFS_SB        8'h04
`define BSE_OFS_SI        8'h08
`define BSE_OFS_SR0       8'h0C
`define BSE_OFS_SR1       8'h10
`define BSE_OFS_SR2       8'h14
`define BSE_OFS_MODE_STATUS_REG     8'h18
`define BSE_OFS_ARITH_STATUS_REG     8'h1C

// Field positions.
`define BSE_BANK_BIT      0
`define BSE_SS_BIT        0

// Shifter and exponent constants.
`define BSE_HI_REF_OFS    9'h010
`define BSE_SE_ALL_SIGN   8'hF1
`define BSE_HI_EXP_BASE   8'h01
`define BSE_LO_EXP_BASE   8'hF1
`define BSE_OVF_EXP       8'h01
`define BSE_HI_ZERO_MIN   8'h18
`define BSE_HI_EXT_MAX    8'hE0
`define BSE_ARR_WIDTH     9'h028

// Reset values.
`define BSE_SE_RST        8'h00
`define BSE_SB_RST        5'h00
`define BSE_SR_RST        40'h00_0000_0000
`define BSE_WORD_RST      16'h0000

`endif

// ===== hdl/bse_pkg.sv
`default_nettype none

package bse_pkg;

  typedef enum logic [1:0] {BSE_OP_SHIFT, BSE_OP_EXP, BSE_OP_EXPADJ} bse_kind_t;
  typedef enum logic [1:0] {BSE_CODE_SE, BSE_CODE_NEG_SE, BSE_CODE_IMM} bse_code_src_t;
  typedef enum logic [1:0] {BSE_EXT_MSB, BSE_EXT_CARRY, BSE_EXT_ZERO} bse_ext_src_t;
  typedef enum logic [1:0] {BSE_DET_HI, BSE_DET_HIX, BSE_DET_LO} bse_det_mode_t;

  typedef struct packed {
    logic          valid;
    bse_kind_t     kind;
    bse_code_src_t code_src;
    logic [7:0]    imm;
    logic          upper_reference;
    bse_ext_src_t  ext_src;
    logic          merge_option;
    bse_det_mode_t det_mode;
    logic          use_si;
    logic [3:0]    src;
  } bse_op_t;

  typedef struct packed {
    logic        en;
    logic        we;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } bse_rf_req_t;

endpackage : bse_pkg

`default_nettype wire

// ===== sim/bse_core_side_model.sv
`default_nettype none

module bse_core_side_model (
  input  wire logic           pclk,
  output var bse_pkg::bse_op_t     op,
  output var bse_pkg::bse_rf_req_t dm_req,
  output var bse_pkg::bse_rf_req_t pm_req,
  output logic                alu_carry_flag,
  output logic                alu_overflow_flag,
  output logic                alt_bank_enable,
  output logic                alt_bank_disable
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    op = '0;
    dm_req = '0;
    pm_req = '0;
    alu_carry_flag = 1'b0;
    alu_overflow_flag = 1'b0;
    alt_bank_enable = 1'b0;
    alt_bank_disable = 1'b0;
  end

  // An instruction holds its slot for exactly one cycle, so the flags travel with it.
  task automatic issue(input bse_pkg::bse_op_t o, input logic cy, input logic ov);
    @(posedge pclk);
    op <= o;
    alu_carry_flag <= cy;
    alu_overflow_flag <= ov;
    @(posedge pclk);
    op <= '0;
  endtask : issue

  // Both buses may carry one transfer in the same cycle.
  task automatic rf(input bse_pkg::bse_rf_req_t d, input bse_pkg::bse_rf_req_t p);
    @(posedge pclk);
    dm_req <= d;
    pm_req <= p;
    @(posedge pclk);
    dm_req <= '0;
    pm_req <= '0;
  endtask : rf

  task automatic bank(input logic en);
    @(posedge pclk);
    alt_bank_enable <= en;
    alt_bank_disable <= !en;
    @(posedge pclk);
    alt_bank_enable <= 1'b0;
    alt_bank_disable <= 1'b0;
  endtask : bank
endmodule : bse_core_side_model

`default_nettype wire

// ===== sim/barrel_shifter_exponent_unit_bench.sv
`include "bse_params.svh"
`default_nettype none

module barrel_shifter_exponent_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cy, ov, ben, bdis, ss, bank;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] dm_rdata, pm_rdata;
  bse_pkg::bse_op_t     op;
  bse_pkg::bse_rf_req_t dm_req, pm_req;
  int          errors;
  int          num_checks;

  localparam logic [7:0] SC[6] = '{8'h04, 8'h00, 8'h00, 8'hFD, 8'h18, 8'hE0};
  localparam int SL[6] = '{4, 16, 0, 13, 40, -16};
  localparam logic [5:0] SU = 6'b111010;
  localparam logic [5:0] XB = 6'b110011;
  localparam bse_pkg::bse_ext_src_t SX[6] = '{bse_pkg::BSE_EXT_MSB, bse_pkg::BSE_EXT_MSB,
    bse_pkg::BSE_EXT_CARRY, bse_pkg::BSE_EXT_ZERO, bse_pkg::BSE_EXT_MSB, bse_pkg::BSE_EXT_MSB};

  bse_core dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op(op), .alu_carry_flag(cy), .alu_overflow_flag(ov),
    .alt_bank_enable(ben), .alt_bank_disable(bdis), .dm_req(dm_req), .pm_req(pm_req),
    .dm_rdata(dm_rdata), .pm_rdata(pm_rdata), .shift_sign_flag(ss), .alt_bank_active(bank));

  bse_core_side_model side_u (.pclk(pclk), .op(op), .dm_req(dm_req), .pm_req(pm_req),
    .alu_carry_flag(cy), .alu_overflow_flag(ov), .alt_bank_enable(ben),
    .alt_bank_disable(bdis));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // The slave answers with no wait states, but the wait stays bounded in case it stalls.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check({8'h00, r}, {8'h00, x});
  endtask : rc

  function automatic logic [39:0] place(logic [15:0] d, int l, logic x);
    for (int i = 0; i < 40; i++) begin
      place[i] = (i < l) ? 1'b0 : (i - l > 15) ? x : d[i - l];
    end
  endfunction : place

  task automatic run(bse_pkg::bse_kind_t k, bse_pkg::bse_code_src_t cs, logic [7:0] im,
      logic up, bse_pkg::bse_ext_src_t x, logic m, bse_pkg::bse_det_mode_t dm,
      logic [4:0] s, logic c, logic o);
    bse_pkg::bse_op_t p;
    p = '0;
    p.valid = 1'b1;
    p.kind = k;
    p.code_src = cs;
    p.imm = im;
    p.upper_reference = up;
    p.ext_src = x;
    p.merge_option = m;
    p.det_mode = dm;
    p.use_si = s[4];
    p.src = s[3:0];
    side_u.issue(p, c, o);
  endtask : run

  task automatic sh(bse_pkg::bse_code_src_t cs, logic [7:0] im, logic up,
      bse_pkg::bse_ext_src_t x, logic m, logic c, logic [4:0] s, logic [39:0] e);
    logic [31:0] a, b, t;
    logic er;
    run(bse_pkg::BSE_OP_SHIFT, cs, im, up, x, m, bse_pkg::BSE_DET_HI, s, c, 1'b0);
    apb(1'b0, `BSE_OFS_SR0, 32'h0, a, er);
    apb(1'b0, `BSE_OFS_SR1, 32'h0, b, er);
    apb(1'b0, `BSE_OFS_SR2, 32'h0, t, er);
    check({t[7:0], b[15:0], a[15:0]}, e);
  endtask : sh

  task automatic ex(bse_pkg::bse_kind_t k, bse_pkg::bse_det_mode_t dm, logic [15:0] si,
      logic o);
    wr(`BSE_OFS_SI, {16'h0000, si});
    run(k, bse_pkg::BSE_CODE_SE, 8'h00, 1'b0, bse_pkg::BSE_EXT_ZERO, 1'b0, dm, 5'h10, 1'b0, o);
  endtask : ex

  task automatic t_reset;
    logic [31:0] r;
    logic e;
    for (int a = 0; a < 32; a += 4) rc(8'(a), 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    check(40'(e), 40'h1);
    check(40'(r), 40'h0);
  endtask : t_reset

  task automatic t_shift;
    wr(`BSE_OFS_SI, 32'h0000A5C3);
    for (int i = 0; i < 6; i++) begin
      sh(bse_pkg::BSE_CODE_IMM, SC[i], SU[i], SX[i], 1'b0, 1'(i != 2), 5'h10,
         place(16'hA5C3, SL[i], XB[i]));
    end
    sh(bse_pkg::BSE_CODE_IMM, 8'h80, 1'b0, bse_pkg::BSE_EXT_MSB, 1'b0, 1'b0, 5'h10,
       place(16'hA5C3, -128, 1'b1));
    sh(bse_pkg::BSE_CODE_IMM, 8'h80, 1'b1, bse_pkg::BSE_EXT_MSB, 1'b0, 1'b0, 5'h10,
       place(16'hA5C3, -112, 1'b1));
    wr(`BSE_OFS_SE, 32'h000000FE);
    rc(`BSE_OFS_SE, 32'h0000FFFE);
    sh(bse_pkg::BSE_CODE_SE, 8'h00, 1'b0, bse_pkg::BSE_EXT_MSB, 1'b0, 1'b0, 5'h10,
       place(16'hA5C3, -2, 1'b1));
    sh(bse_pkg::BSE_CODE_NEG_SE, 8'h00, 1'b1, bse_pkg::BSE_EXT_MSB, 1'b0, 1'b0, 5'h10,
       place(16'hA5C3, 18, 1'b1));
    sh(bse_pkg::BSE_CODE_SE, 8'h00, 1'b0, bse_pkg::BSE_EXT_MSB, 1'b1, 1'b0, 5'h10,
       place(16'hA5C3, 18, 1'b1) | place(16'hA5C3, -2, 1'b1));
    sh(bse_pkg::BSE_CODE_SE, 8'h00, 1'b0, bse_pkg::BSE_EXT_MSB, 1'b0, 1'b0, 5'h10,
       place(16'hA5C3, -2, 1'b1));
  endtask : t_shift

  task automatic t_exp;
    ex(bse_pkg::BSE_OP_EXP, bse_pkg::BSE_DET_HI, 16'h0F00, 1'b0);
    rc(`BSE_OFS_SE, 32'h0000FFFD);
    rc(`BSE_OFS_ARITH_STATUS_REG, 32'h0);
    ex(bse_pkg::BSE_OP_EXP, bse_pkg::BSE_DET_HIX, 16'h0F00, 1'b1);
    rc(`BSE_OFS_SE, 32'h00000001);
    check(40'(ss), 40'h1);
    ex(bse_pkg::BSE_OP_EXP, bse_pkg::BSE_DET_HIX, 16'hF0F0, 1'b0);
    rc(`BSE_OFS_SE, 32'h0000FFFD);
    ex(bse_pkg::BSE_OP_EXP, bse_pkg::BSE_DET_HI, 16'hFFFF, 1'b0);
    rc(`BSE_OFS_SE, 32'h0000FFF1);
    ex(bse_pkg::BSE_OP_EXP, bse_pkg::BSE_DET_LO, 16'h0F00, 1'b0);
    rc(`BSE_OFS_SE, 32'h0000FFF1);
    ex(bse_pkg::BSE_OP_EXP, bse_pkg::BSE_DET_LO, 16'hF6D4, 1'b0);
    rc(`BSE_OFS_SE, 32'h0000FFED);
    ex(bse_pkg::BSE_OP_EXP, bse_pkg::BSE_DET_LO, 16'h0F00, 1'b0);
    rc(`BSE_OFS_SE, 32'h0000FFED);
    rc(`BSE_OFS_ARITH_STATUS_REG, 32'h1);
  endtask : t_exp

  task automatic t_blk;
    ex(bse_pkg::BSE_OP_EXPADJ, bse_pkg::BSE_DET_HI, 16'h0F00, 1'b0);
    rc(`BSE_OFS_SB, 32'h0);
    wr(`BSE_OFS_SB, 32'h00000018);
    rc(`BSE_OFS_SB, 32'h0000FFF8);
    ex(bse_pkg::BSE_OP_EXPADJ, bse_pkg::BSE_DET_HI, 16'h0F00, 1'b0);
    rc(`BSE_OFS_SB, 32'h0000FFFD);
    ex(bse_pkg::BSE_OP_EXPADJ, bse_pkg::BSE_DET_HI, 16'h0400, 1'b0);
    rc(`BSE_OFS_SB, 32'h0000FFFD);
    rc(`BSE_OFS_SE, 32'h0000FFED);
  endtask : t_blk

  task automatic t_bank;
    wr(`BSE_OFS_SE, 32'h00000005);
    wr(`BSE_OFS_MODE_STATUS_REG, 32'h00000001);
    #1;
    check(40'(bank), 40'h0);
    @(posedge pclk);
    #1;
    check(40'(bank), 40'h1);
    rc(`BSE_OFS_SE, 32'h0);
    rc(`BSE_OFS_SB, 32'h0);
    side_u.bank(1'b0);
    #1;
    check(40'(bank), 40'h0);
    rc(`BSE_OFS_SE, 32'h00000005);
    side_u.bank(1'b1);
    #1;
    check(40'(bank), 40'h1);
    side_u.bank(1'b0);
  endtask : t_bank

  task automatic t_rf;
    side_u.rf('{1'b1, 1'b1, 4'hF, 16'h1234}, '{1'b1, 1'b1, 4'hF, 16'hABCD});
    side_u.rf('{1'b1, 1'b0, 4'hF, 16'h0000}, '{1'b1, 1'b1, 4'hF, 16'h5555});
    #1;
    check(40'(dm_rdata), 40'h1234);
    side_u.rf('{1'b1, 1'b0, 4'h0, 16'h0000}, '{1'b1, 1'b0, 4'hF, 16'h0000});
    #1;
    check(40'(dm_rdata), 40'h0);
    check(40'(pm_rdata), 40'h5555);
    sh(bse_pkg::BSE_CODE_IMM, 8'h00, 1'b0, bse_pkg::BSE_EXT_MSB, 1'b0, 1'b0, 5'h0F,
       place(16'h5555, 0, 1'b0));
  endtask : t_rf

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    errors = 0;
    num_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_shift;
    t_exp;
    t_blk;
    t_bank;
    t_rf;
    print_verdict;
  end

  // The whole sequence needs a few hundred cycles; this leaves ample margin.
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    print_verdict;
  end
endmodule : barrel_shifter_exponent_unit_bench

`default_nettype wire
